/* core/ilb_pkg.sv */
package ilb_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_COVER = 8'h52;
  localparam logic [7:0] IDX_WAKE_STS = 8'h53;
  localparam logic [7:0] IDX_WAKE_EN = 8'h54;
  localparam logic [7:0] IDX_PB_EN = 8'h55;
  localparam logic [7:0] IDX_IRQ_STS = 8'h56;
  localparam logic [7:0] IDX_IRQ_EN = 8'h57;
  localparam logic [7:0] IDX_PWR = 8'h58;
  // Bit positions
  localparam int B_TAMPER = 0;
  localparam int B_LIVE = 1;
  localparam int B_LOWBAT = 1;
  // Synchroniser slots
  localparam int S_COVER = 0;
  localparam int S_LOWBAT = 1;
  localparam int S_STBY = 2;
  localparam int S_MAIN = 3;
  localparam int S_BATPOR = 4;
  localparam int S_STBYPOR = 5;
  localparam int S_MAINPOR = 6;
  localparam int NSYNC = 7;
  localparam logic [NSYNC-1:0] SYNC_RST = 7'h01;

  typedef struct packed {
    logic lowbat;
    logic tamper;
  } ilb_grp_t;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] prev;
    logic tamper;
    logic held;
    logic bat_pend;
    ilb_grp_t wake_sts;
    ilb_grp_t wake_en;
    ilb_grp_t irq_sts;
    ilb_grp_t irq_en;
    logic pb_en;
    logic wr;
    logic [7:0] widx;
    logic [31:0] rdata;
    logic wake;
    logic pb;
    logic irq;
  } ilb_state_t;

  localparam ilb_grp_t GRP_NONE = 2'h0;
  localparam ilb_grp_t GRP_LOWBAT = 2'h2;
  localparam ilb_state_t ILB_RST = '{
    s1: SYNC_RST, s2: SYNC_RST, prev: SYNC_RST,
    tamper: 1'b1, held: 1'b0, bat_pend: 1'b0,
    wake_sts: GRP_LOWBAT, wake_en: GRP_NONE,
    irq_sts: GRP_LOWBAT, irq_en: GRP_NONE,
    pb_en: 1'b1, wr: 1'b0, widx: 8'h00, rdata: 32'h0,
    wake: 1'b0, pb: 1'b0, irq: 1'b0};
endpackage : ilb_pkg

/* core/ilb_events.sv */
`timescale 1ns/1ps
`default_nettype none
module ilb_events
  import ilb_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Pins and power wiring
  input wire logic i_chassis_cover_input_n,
  input wire logic i_battery_low_flag,
  input wire logic i_standby_power,
  input wire logic i_main_power,
  input wire logic i_battery_domain_reset,
  input wire logic i_standby_domain_reset,
  input wire logic i_main_domain_reset,
  // Other event sources
  input wire logic i_other_wake,
  input wire logic i_other_button,
  input wire logic i_other_irq,
  // Event outputs
  output logic o_wake_event_out,
  output logic o_power_button_out,
  output logic o_mgmt_irq
);

  ilb_state_t q;
  ilb_state_t n;
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] rise;
  logic cov_evt;
  logic stby_on;
  logic main_on;
  logic bat_apply;
  logic accept;
  logic [7:0] wd;

  function automatic logic [7:0] reg_index(input logic [31:0] a);
    reg_index = a[9:2];
  endfunction : reg_index

  function automatic logic [31:0] read_mux(input logic [7:0] i, input ilb_state_t s);
    read_mux = 32'h0;
    unique case (i)
      IDX_COVER: read_mux = {30'h0, !s.s2[S_COVER], s.tamper};
      IDX_WAKE_STS: read_mux = {30'h0, s.wake_sts};
      IDX_WAKE_EN: read_mux = {30'h0, s.wake_en};
      IDX_PB_EN: read_mux = {31'h0, s.pb_en};
      IDX_IRQ_STS: read_mux = {30'h0, s.irq_sts};
      IDX_IRQ_EN: read_mux = {30'h0, s.irq_en};
      IDX_PWR: read_mux = {29'h0, s.held, s.s2[S_MAIN], s.s2[S_STBY]};
      default: read_mux = 32'h0;
    endcase
  endfunction : read_mux

  assign pins = {i_main_domain_reset, i_standby_domain_reset, i_battery_domain_reset,
                 i_main_power, i_standby_power, i_battery_low_flag, i_chassis_cover_input_n};
  assign rise = q.s2 & ~q.prev;
  assign cov_evt = q.s2[S_COVER] ^ q.prev[S_COVER];
  assign stby_on = q.s2[S_STBY];
  assign main_on = q.s2[S_MAIN];
  // A battery reset seen with standby off waits for the standby reset
  assign bat_apply = (rise[S_BATPOR] && stby_on) || (rise[S_STBYPOR] && q.bat_pend);
  assign accept = i_hsel && i_hready && i_htrans[1];
  assign wd = i_hwdata[7:0];

  always_comb begin
    n = q;
    n.s1 = pins;
    n.s2 = q.s1;
    n.prev = q.s2;
    // Bus: address phase captured, write applied in the data phase
    n.wr = accept && i_hwrite;
    n.widx = reg_index(i_haddr);
    if (accept && !i_hwrite) begin
      n.rdata = read_mux(reg_index(i_haddr), q);
    end
    // Clears first, so that a same-cycle hardware set wins
    if (q.wr) begin
      unique case (q.widx)
        IDX_COVER: if (!wd[B_TAMPER]) n.tamper = 1'b0;
        IDX_WAKE_STS: n.wake_sts = q.wake_sts & ~ilb_grp_t'(wd[1:0]);
        IDX_IRQ_STS: n.irq_sts = q.irq_sts & ~ilb_grp_t'(wd[1:0]);
        IDX_WAKE_EN: n.wake_en = ilb_grp_t'(wd[1:0]);
        IDX_IRQ_EN: n.irq_en = ilb_grp_t'(wd[1:0]);
        IDX_PB_EN: n.pb_en = wd[B_TAMPER];
        default: n.wr = n.wr;
      endcase
    end
    if (cov_evt) begin
      n.tamper = 1'b1;
      // Shadows rise only from a clear flag; off standby the shadow copy at reset does it
      if (!q.tamper && stby_on) begin
        n.wake_sts.tamper = 1'b1;
        n.irq_sts.tamper = 1'b1;
      end
    end
    // Comparator level held until the main-domain reset posts it
    if (q.s2[S_LOWBAT] && !main_on) begin
      n.held = 1'b1;
    end
    if (rise[S_MAINPOR]) begin
      n.wake_sts.lowbat = q.wake_sts.lowbat | q.held;
      n.irq_sts.lowbat = q.irq_sts.lowbat | q.held;
      n.held = 1'b0;
    end
    if (rise[S_BATPOR] && !stby_on) begin
      n.bat_pend = 1'b1;
    end
    if (bat_apply) begin
      n.tamper = 1'b1;
      n.pb_en = 1'b1;
      n.wake_sts.lowbat = 1'b1;
      n.irq_sts.lowbat = 1'b1;
      n.bat_pend = 1'b0;
    end
    if (rise[S_STBYPOR]) begin
      n.wake_en = GRP_NONE;
      n.irq_en = GRP_NONE;
      n.wake_sts.tamper = n.tamper;
      n.irq_sts.tamper = n.tamper;
    end
    // Level requests: enable rising over a set status fires as well
    n.wake = i_other_wake || (stby_on && ((q.wake_sts.tamper && q.wake_en.tamper)
             || (main_on && q.wake_sts.lowbat && q.wake_en.lowbat)));
    n.pb = i_other_button || (stby_on && q.wake_sts.tamper && q.pb_en);
    // Interrupt held back until main power is up
    n.irq = i_other_irq || (main_on && |(q.irq_sts & q.irq_en));
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      q <= ILB_RST;
    end else if (i_ce) begin
      q <= n;
    end
  end

  // Every access completes with zero wait states unless frozen
  assign o_hreadyout = i_ce;
  assign o_hresp = 1'b0;
  assign o_hrdata = q.rdata;
  assign o_wake_event_out = q.wake;
  assign o_power_button_out = q.pb;
  assign o_mgmt_irq = q.irq;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  cover_set_a: assert property (i_ce && cov_evt |=> q.tamper)
    else $error("cover edge did not set tamper flag");
  tamper_clr_a: assert property (i_ce && q.wr && q.widx == IDX_COVER && !i_hwdata[0] && !cov_evt && !bat_apply
    |=> !q.tamper)
    else $error("tamper flag not cleared by zero write");
  live_bit_a: assert property (i_ce && accept && !i_hwrite && reg_index(i_haddr) == IDX_COVER
    |=> o_hrdata[B_LIVE] == !$past(q.s2[S_COVER]))
    else $error("live state bit not inverse of input");
  bat_reset_a: assert property (i_ce && bat_apply
    |=> q.tamper && q.pb_en && q.wake_sts.lowbat && q.irq_sts.lowbat)
    else $error("battery reset defaults wrong");
  sts_w1c_a: assert property (i_ce && q.wr && q.widx == IDX_WAKE_STS && i_hwdata[0] && !cov_evt && !rise[S_STBYPOR]
    |=> !q.wake_sts.tamper)
    else $error("wake status not cleared by one write");
  no_reset_a: assert property (i_ce && q.tamper && !q.irq_sts.tamper && !rise[S_STBYPOR]
    |=> !q.irq_sts.tamper)
    else $error("status set again while flag still set");
  stby_en_a: assert property (i_ce && rise[S_STBYPOR] |=> q.wake_en == GRP_NONE && q.irq_en == GRP_NONE)
    else $error("standby reset left enables set");
  irq_gate_a: assert property (i_ce && !main_on && !i_other_irq |=> !o_mgmt_irq)
    else $error("interrupt raised without main power");
  lowbat_hold_a: assert property (i_ce && !rise[S_MAINPOR] && !bat_apply && !q.wake_sts.lowbat
    |=> !q.wake_sts.lowbat)
    else $error("low battery status set outside main reset");
  lowbat_wake_a: assert property (i_ce && !main_on && !(q.wake_sts.tamper && q.wake_en.tamper) && !i_other_wake
    |=> !o_wake_event_out)
    else $error("low battery woke under standby");
  // Output paths: one cycle from status and enable to the registered request
  wake_and_a: assert property (i_ce && stby_on && q.wake_sts.tamper && q.wake_en.tamper |=> o_wake_event_out)
    else $error("enabled tamper wake not raised");
  pb_and_a: assert property (i_ce && stby_on && q.wake_sts.tamper && q.pb_en |=> o_power_button_out)
    else $error("enabled tamper button request not raised");
  pb_gate_a: assert property (i_ce && !stby_on && !i_other_button |=> !o_power_button_out)
    else $error("button request raised without standby power");
  irq_and_a: assert property (i_ce && main_on && (|(q.irq_sts & q.irq_en)) |=> o_mgmt_irq)
    else $error("enabled interrupt not raised under main power");
  // Shadow bits follow the flag on a fresh event and at standby reset
  shadow_set_a: assert property (i_ce && cov_evt && !q.tamper && stby_on
    |=> q.wake_sts.tamper && q.irq_sts.tamper)
    else $error("tamper status shadows not set by cover edge");
  stby_copy_a: assert property (i_ce && rise[S_STBYPOR]
    |=> q.wake_sts.tamper == q.tamper && q.irq_sts.tamper == q.tamper)
    else $error("standby reset did not copy tamper flag to status");
  irq_w1c_a: assert property (i_ce && q.wr && q.widx == IDX_IRQ_STS && i_hwdata[0] && !cov_evt && !rise[S_STBYPOR]
    |=> !q.irq_sts.tamper)
    else $error("interrupt status not cleared by one write");
  sts_w0_a: assert property (i_ce && q.wr && q.widx == IDX_WAKE_STS && !i_hwdata[0] && q.wake_sts.tamper
    && !rise[S_STBYPOR] |=> q.wake_sts.tamper)
    else $error("zero write changed wake status");
  pb_keep_a: assert property (i_ce && !bat_apply && !(q.wr && q.widx == IDX_PB_EN)
    |=> q.pb_en == $past(q.pb_en))
    else $error("button enable changed without write or battery reset");
  // Low battery path: latched off main power, posted by the main reset; an applied battery reset also sets both statuses
  held_set_a: assert property (i_ce && q.s2[S_LOWBAT] && !main_on |=> q.held)
    else $error("low battery level not held");
  main_post_a: assert property (i_ce && rise[S_MAINPOR] && q.held
    |=> q.wake_sts.lowbat && q.irq_sts.lowbat && !q.held)
    else $error("held low battery not posted at main reset");
  irq_lowbat_a: assert property (i_ce && !rise[S_MAINPOR] && !bat_apply && !q.irq_sts.lowbat
    |=> !q.irq_sts.lowbat)
    else $error("low battery interrupt status set outside main reset");
  bat_pend_a: assert property (i_ce && rise[S_BATPOR] && !stby_on |=> q.bat_pend)
    else $error("battery reset without standby not deferred");
  evt_wake_c: cover property (i_ce && cov_evt && !q.tamper && stby_on && q.wake_en.tamper);
  stby_only_c: cover property (i_ce && cov_evt && stby_on && !main_on);
  post_lowbat_c: cover property (i_ce && rise[S_MAINPOR] && q.held);
  pend_bat_c: cover property (i_ce && rise[S_STBYPOR] && q.bat_pend);
  irq_on_c: cover property (o_mgmt_irq && !i_other_irq);

endmodule : ilb_events
`default_nettype wire

/* tb/ilb_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module ilb_partner (
  // Clock
  input wire logic i_mclk,
  // Cover switch and power wiring
  output logic o_cover_n,
  output logic o_bat_low,
  output logic o_stby,
  output logic o_main,
  output logic o_bat_rst,
  output logic o_stby_rst,
  output logic o_main_rst
);
  // The cover line idles high through its pull-up
  initial begin
    o_cover_n = 1'b1;
    o_bat_low = 1'b0;
    o_stby = 1'b1;
    o_main = 1'b1;
    o_bat_rst = 1'b0;
    o_stby_rst = 1'b0;
    o_main_rst = 1'b0;
  end
  task flip;
    @(posedge i_mclk);
    o_cover_n <= ~o_cover_n;
  endtask : flip
  task pwr(input logic m, input logic b);
    @(posedge i_mclk);
    o_main <= m;
    o_bat_low <= b;
  endtask : pwr
  task rails(input logic s, input logic m);
    @(posedge i_mclk);
    o_stby <= s;
    o_main <= m;
  endtask : rails
  // Battery and standby resets as short pulses
  task dom_por(input logic b, input logic s);
    @(posedge i_mclk);
    o_bat_rst <= b;
    o_stby_rst <= s;
    repeat (4) @(posedge i_mclk);
    o_bat_rst <= 1'b0;
    o_stby_rst <= 1'b0;
  endtask : dom_por
  // Main-domain reset is a short pulse once main power is up
  task main_por;
    @(posedge i_mclk);
    o_main_rst <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_main_rst <= 1'b0;
  endtask : main_por
endmodule : ilb_partner
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import ilb_pkg::*;
;
  logic clk, rst_n, hsel, hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rd, hrdata;
  logic hrdy, hresp, wake, pb, irq, cov_n, blow, stby, mainp, brst, srst, mrst;
  int bad_count = 0;
  int check_count = 0;
  ilb_partner pu (.i_mclk(clk), .o_cover_n(cov_n), .o_bat_low(blow), .o_stby(stby), .o_main(mainp),
    .o_bat_rst(brst), .o_stby_rst(srst), .o_main_rst(mrst));
  ilb_events dut_u (.i_mclk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_chassis_cover_input_n(cov_n),
    .i_battery_low_flag(blow), .i_standby_power(stby), .i_main_power(mainp),
    .i_battery_domain_reset(brst), .i_standby_domain_reset(srst), .i_main_domain_reset(mrst),
    .i_other_wake(1'b0), .i_other_button(1'b0), .i_other_irq(1'b0),
    .o_wake_event_out(wake), .o_power_button_out(pb), .o_mgmt_irq(irq));
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // No wait-state count is assumed; the bound only guards a hang
  task bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      bad_count++;
      report_and_stop();
    end
  endtask : bus
  task rdc(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0);
  endtask : rdc
  task outs(input logic [2:0] e);
    repeat (2) @(posedge clk);
    chk({29'h0, wake, pb, irq}, {29'h0, e});
  endtask : outs
  task t_reset;
    rdc(IDX_COVER, 32'h1);
    rdc(IDX_WAKE_STS, 32'h2);
    rdc(IDX_IRQ_STS, 32'h2);
    rdc(IDX_PB_EN, 32'h1);
    rdc(IDX_WAKE_EN, 32'h0);
    rdc(8'h10, 32'h0);
    bus(1'b1, IDX_COVER, 32'h1);
    rdc(IDX_COVER, 32'h1);
    bus(1'b1, IDX_COVER, 32'h0);
    rdc(IDX_COVER, 32'h0);
  endtask : t_reset
  task t_cover;
    bus(1'b1, IDX_WAKE_STS, 32'h3);
    bus(1'b1, IDX_IRQ_STS, 32'h3);
    bus(1'b1, IDX_WAKE_EN, 32'h1);
    bus(1'b1, IDX_IRQ_EN, 32'h1);
    pu.flip();
    repeat (8) @(posedge clk);
    rdc(IDX_COVER, 32'h3);
    rdc(IDX_WAKE_STS, 32'h1);
    outs(3'h7);
    bus(1'b1, IDX_WAKE_STS, 32'h0);
    rdc(IDX_WAKE_STS, 32'h1);
    bus(1'b1, IDX_WAKE_STS, 32'h1);
    bus(1'b1, IDX_IRQ_STS, 32'h1);
    bus(1'b1, IDX_PB_EN, 32'h0);
    outs(3'h0);
    pu.flip();
    repeat (8) @(posedge clk);
    rdc(IDX_IRQ_STS, 32'h0);
    rdc(IDX_COVER, 32'h1);
  endtask : t_cover
  task t_enable;
    bus(1'b1, IDX_WAKE_EN, 32'h0);
    bus(1'b1, IDX_IRQ_EN, 32'h0);
    bus(1'b1, IDX_COVER, 32'h0);
    pu.flip();
    repeat (8) @(posedge clk);
    outs(3'h0);
    bus(1'b1, IDX_IRQ_EN, 32'h1);
    outs(3'h1);
    pu.pwr(1'b0, 1'b0);
    repeat (8) @(posedge clk);
    outs(3'h0);
    pu.pwr(1'b1, 1'b0);
  endtask : t_enable
  task t_lowbat;
    bus(1'b1, IDX_WAKE_STS, 32'h3);
    bus(1'b1, IDX_IRQ_STS, 32'h3);
    bus(1'b1, IDX_IRQ_EN, 32'h0);
    bus(1'b1, IDX_WAKE_EN, 32'h2);
    pu.pwr(1'b1, 1'b1);
    repeat (8) @(posedge clk);
    rdc(IDX_WAKE_STS, 32'h0);
    pu.pwr(1'b0, 1'b1);
    repeat (8) @(posedge clk);
    outs(3'h0);
    pu.pwr(1'b1, 1'b1);
    pu.main_por();
    repeat (8) @(posedge clk);
    rdc(IDX_WAKE_STS, 32'h2);
    outs(3'h4);
  endtask : t_lowbat
  // Standby-only and battery-only power: deferred battery reset, withheld interrupt
  task t_standby;
    bus(1'b1, IDX_COVER, 32'h0);
    bus(1'b1, IDX_WAKE_STS, 32'h3);
    bus(1'b1, IDX_IRQ_STS, 32'h3);
    bus(1'b1, IDX_WAKE_EN, 32'h1);
    bus(1'b1, IDX_PB_EN, 32'h0);
    pu.pwr(1'b0, 1'b0);
    pu.rails(1'b0, 1'b0);
    repeat (8) @(posedge clk);
    pu.flip();
    repeat (8) @(posedge clk);
    rdc(IDX_WAKE_STS, 32'h0);
    rdc(IDX_PWR, 32'h0);
    outs(3'h0);
    pu.dom_por(1'b1, 1'b0);
    repeat (8) @(posedge clk);
    rdc(IDX_PB_EN, 32'h0);
    pu.rails(1'b1, 1'b0);
    pu.dom_por(1'b0, 1'b1);
    repeat (8) @(posedge clk);
    rdc(IDX_PB_EN, 32'h1);
    rdc(IDX_WAKE_STS, 32'h3);
    rdc(IDX_WAKE_EN, 32'h0);
    rdc(IDX_IRQ_EN, 32'h0);
    outs(3'h2);
    bus(1'b1, IDX_IRQ_EN, 32'h1);
    outs(3'h2);
    pu.rails(1'b1, 1'b1);
    repeat (8) @(posedge clk);
    outs(3'h3);
  endtask : t_standby
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_cover();
    t_enable();
    t_lowbat();
    t_standby();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
